/* File: timer_pair.sv */
// Purpose: Two timer/counter units with four modes and a register port
// Assumes: clock_i is the machine-cycle rate; register strobes are one cycle
// Notes:   Read data is valid only in the cycle after the read strobe
//
// Notes on behaviour
// - Select bit picks timer or counter
// - Four modes per unit, mode 3 differs
// - Mode 0 13-bit count, wrap sets flag
// - Mode 0 uses high byte, low five bits
// - Count needs run and (no gate or pin)
// - Setting run keeps count bytes
// - Pin-qualify bits at mode bits 7 and 3
// - Mode 1 counts all sixteen bits
// - Mode 2 low byte reloads from high
// - Mode 2 reload leaves high byte alone
// - Unit 1 mode 3 holds count
// - Unit 0 mode 3 low byte own counter
// - Unit 0 mode 3 high byte uses unit 1
// - Unit 1 still runs, overflow feeds baud
`timescale 1ns/1ps
`include "timer_pair_defs.svh"

module timer_pair
   import timer_pair_pkg::*;
(
   input  wire logic                clock_i,     // 10 MHz machine clock
   input  wire logic                rstn_i,      // Async reset, active low
   input  wire logic [`ADDR_W-1:0]  addr_i,      // Register address
   input  wire logic [`DATA_W-1:0]  wdata_i,     // Write data
   input  wire logic                wr_i,        // Write strobe
   input  wire logic                rd_i,        // Read strobe
   input  wire logic                unit0_irq_pin_i,  // Unit 0 gate pin
   input  wire logic                unit1_irq_pin_i,  // Unit 1 gate pin
   input  wire logic                count0_pin_i,     // Unit 0 count input
   input  wire logic                count1_pin_i,     // Unit 1 count input
   output logic [`DATA_W-1:0]       rdata_o,     // Read data
   output logic                     irq_o,       // Interrupt level
   output logic [1:0]               overflow_flag_o,  // Overflow flags
   output logic                     baud_tick_o  // Unit 1 overflow pulse
);

   // ********************************************************************
   // Reset release
   // ********************************************************************
   logic rst_meta_q;                 // First stage, read only by second
   logic rst_n_q;                    // Reset copy for the block

   // Release through two flops to avoid metastable release
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ********************************************************************
   // State
   // ********************************************************************
   logic [7:0] mode_q;               // Shared mode register
   logic [1:0] run_q;                // Run bits
   logic [1:0] ovf_q;                // Overflow flags
   logic [7:0] low_q  [2];           // Low count bytes
   logic [7:0] high_q [2];           // High count bytes
   logic [1:0] stat_q;               // Sticky event status
   logic [1:0] ien_q;                // Interrupt enables
   logic [7:0] rdata_q;              // Read data
   logic       irq_q;                // Interrupt output
   logic       baud_q;               // Baud pulse

   // ********************************************************************
   // Decode
   // ********************************************************************
   logic        wr_mode, wr_ctrl, wr_clr, wr_en;  // Register write hits
   logic [1:0]  wr_low, wr_high;     // Count byte write hits
   logic [1:0]  gate, sel;           // Per-unit pin qualify and select
   mode_t       mode [2];            // Per-unit mode
   logic [1:0]  tick;                // Per-unit count enable
   logic [7:0]  low_d  [2];          // Next low bytes from counting
   logic [7:0]  high_d [2];          // Next high bytes from counting
   logic        wrap [2];            // Per-unit own overflow
   logic        hi0_wrap;            // Split high byte overflow
   logic [1:0]  ovf_set;             // Flag set events
   logic [1:0]  gate_pins, cnt_pins; // Pins as vectors

   assign wr_mode = wr_i && (addr_i == `OFS_MODE);
   assign wr_ctrl = wr_i && (addr_i == `OFS_CTRL);
   assign wr_clr  = wr_i && (addr_i == `OFS_IRQ_CLR);
   assign wr_en   = wr_i && (addr_i == `OFS_IRQ_EN);
   assign wr_low  = {wr_i && (addr_i == `OFS_LOW1),  wr_i && (addr_i == `OFS_LOW0)};
   assign wr_high = {wr_i && (addr_i == `OFS_HIGH1), wr_i && (addr_i == `OFS_HIGH0)};
   assign gate_pins = {unit1_irq_pin_i, unit0_irq_pin_i};
   assign cnt_pins  = {count1_pin_i, count0_pin_i};

   // ********************************************************************
   // Per-unit count path
   // ********************************************************************
   for (genvar n = 0; n < 2; n++) begin : g_unit
      // Unit n nibble: bit 3 qualify, bit 2 select, bits 1:0 mode
      assign gate[n] = mode_q[n*`UNIT_STRIDE + `GATE_BIT];
      assign sel[n]  = mode_q[n*`UNIT_STRIDE + `SEL_BIT];
      assign mode[n] = mode_t'(mode_q[n*`UNIT_STRIDE + `MODE_LSB +: 2]);

      count_source u_src (
         .clock_i       (clock_i),
         .rst_n_i       (rst_n_q),
         .run_i         (run_q[n]),
         .gate_en_i     (gate[n]),
         .gate_pin_i    (gate_pins[n]),
         .counter_sel_i (sel[n]),
         .count_pin_i   (cnt_pins[n]),
         .tick_o        (tick[n])
      );

      // Next count from the unit's mode
      always_comb begin
         low_d[n]  = low_q[n];
         high_d[n] = high_q[n];
         wrap[n]   = 1'b0;
         case (mode[n])
            MODE_PRESCALE13: begin
               // Only the low five bits carry; upper three are left alone
               if (tick[n]) begin
                  low_d[n][4:0] = low_q[n][4:0] + 5'h01;
                  if (low_q[n][4:0] == 5'h1F) begin
                     high_d[n] = high_q[n] + 8'h01;
                     wrap[n]   = (high_q[n] == 8'hFF);
                  end
               end
            end
            MODE_COUNT16: begin
               if (tick[n]) begin
                  low_d[n] = low_q[n] + 8'h01;
                  if (low_q[n] == 8'hFF) begin
                     high_d[n] = high_q[n] + 8'h01;
                     wrap[n]   = (high_q[n] == 8'hFF);
                  end
               end
            end
            MODE_RELOAD8: begin
               // High byte is the reload value and never moves
               if (tick[n]) begin
                  if (low_q[n] == 8'hFF) begin
                     low_d[n] = high_q[n];
                     wrap[n]  = 1'b1;
                  end else begin
                     low_d[n] = low_q[n] + 8'h01;
                  end
               end
            end
            MODE_SPLIT: begin
               // Unit 1 holds here; unit 0 low byte runs on its own
               if (n == 0 && tick[n]) begin
                  low_d[n] = low_q[n] + 8'h01;
                  wrap[n]  = (low_q[n] == 8'hFF);
               end
            end
            default: begin
               wrap[n] = 1'b0;
            end
         endcase
      end
   end

   // ********************************************************************
   // Split high byte of unit 0
   // ********************************************************************
   logic split0;                     // Unit 0 in split mode
   logic [7:0] hi0_split;            // Split high byte next value

   assign split0 = (mode[0] == MODE_SPLIT);

   // Machine cycles only, run by unit 1's run bit, no gate pin
   always_comb begin
      hi0_split = high_q[0];
      hi0_wrap  = 1'b0;
      if (split0 && run_q[1]) begin
         hi0_split = high_q[0] + 8'h01;
         hi0_wrap  = (high_q[0] == 8'hFF);
      end
   end

   // Unit 1 flag belongs to the split high byte while unit 0 splits
   assign ovf_set[0] = wrap[0];
   assign ovf_set[1] = split0 ? hi0_wrap : wrap[1];

   // ********************************************************************
   // Count bytes
   // ********************************************************************
   // Software write wins over a count in the same cycle
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         low_q[0]  <= `COUNT_RST;
         low_q[1]  <= `COUNT_RST;
         high_q[0] <= `COUNT_RST;
         high_q[1] <= `COUNT_RST;
      end else begin
         for (int k = 0; k < 2; k++) begin
            low_q[k]  <= wr_low[k]  ? wdata_i : low_d[k];
            high_q[k] <= wr_high[k] ? wdata_i : high_d[k];
         end
         if (!wr_high[0] && split0) begin
            high_q[0] <= hi0_split;
         end
      end
   end

   // ********************************************************************
   // Mode and control registers
   // ********************************************************************
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode_q <= `MODE_RST;
      end else if (wr_mode) begin
         mode_q <= wdata_i;
      end
   end

   // Run bits touch no count byte; a flag set beats a software clear
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         run_q <= 2'h0;
         ovf_q <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            run_q <= {wdata_i[`RUN1_BIT], wdata_i[`RUN0_BIT]};
         end
         ovf_q <= (wr_ctrl ? {wdata_i[`OVF1_BIT], wdata_i[`OVF0_BIT]} : ovf_q)
                  | ovf_set;
      end
   end

   // ********************************************************************
   // Interrupt status and output
   // ********************************************************************
   // Sticky status; set wins over the write-one clear
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stat_q <= 2'h0;
         ien_q  <= 2'h0;
      end else begin
         stat_q <= (stat_q & ~(wr_clr ? wdata_i[1:0] : 2'h0)) | ovf_set;
         if (wr_en) begin
            ien_q <= wdata_i[1:0];
         end
      end
   end

   // Registered level, one cycle behind status
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq_q  <= 1'b0;
         baud_q <= 1'b0;
      end else begin
         irq_q  <= |(stat_q & ien_q);
         baud_q <= wrap[1];
      end
   end

   // ********************************************************************
   // Read port
   // ********************************************************************
   // Data only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `OFS_MODE:     rdata_q <= mode_q;
            `OFS_CTRL:     rdata_q <= {ovf_q[1], run_q[1], ovf_q[0], run_q[0], 4'h0};
            `OFS_LOW0:     rdata_q <= low_q[0];
            `OFS_LOW1:     rdata_q <= low_q[1];
            `OFS_HIGH0:    rdata_q <= high_q[0];
            `OFS_HIGH1:    rdata_q <= high_q[1];
            `OFS_IRQ_STAT: rdata_q <= {6'h00, stat_q};
            `OFS_IRQ_EN:   rdata_q <= {6'h00, ien_q};
            default:       rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_o         = rdata_q;
   assign irq_o           = irq_q;
   assign overflow_flag_o = ovf_q;
   assign baud_tick_o     = baud_q;

   // ********************************************************************
   // Checks
   // ********************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_q);

   a_mode0_wrap: assert property (
      (mode[0] == MODE_PRESCALE13 && tick[0] && !wr_i &&
       low_q[0][4:0] == 5'h1F && high_q[0] == 8'hFF)
      |=> (ovf_q[0] && high_q[0] == 8'h00 && low_q[0][4:0] == 5'h00))
      else $error("mode 0 wrap did not set flag");

   a_upper_bits: assert property (
      (mode[0] == MODE_PRESCALE13 && !wr_i) |=> $stable(low_q[0][7:5]))
      else $error("mode 0 upper low bits moved");

   a_gate_block: assert property (
      !(run_q[1] && (!gate[1] || unit1_irq_pin_i)) |-> !tick[1])
      else $error("unit 1 counted while gated");

   a_mode1_carry: assert property (
      (mode[1] == MODE_COUNT16 && tick[1] && !wr_i && low_q[1] == 8'hFF &&
       high_q[1] != 8'hFF)
      |=> (low_q[1] == 8'h00 && high_q[1] == $past(high_q[1]) + 8'h01))
      else $error("mode 1 carry wrong");

   a_reload_hold: assert property (
      (mode[1] == MODE_RELOAD8 && tick[1] && !wr_i && low_q[1] == 8'hFF)
      |=> (low_q[1] == $past(high_q[1]) && $stable(high_q[1]) && ovf_q[1]))
      else $error("mode 2 reload wrong");

   a_unit1_hold: assert property (
      (mode[1] == MODE_SPLIT && !wr_i) [*2]
      |-> ($stable(low_q[1]) && $stable(high_q[1])))
      else $error("unit 1 moved in mode 3");

   a_split_high: assert property (
      (split0 && run_q[1] && !wr_i && high_q[0] == 8'hFF)
      |=> (ovf_q[1] && stat_q[1] && high_q[0] == 8'h00))
      else $error("split high overflow lost");

   a_timer_tick: assert property (
      (run_q[0] && !gate[0] && !sel[0] && mode[0] == MODE_COUNT16 && !wr_i &&
       low_q[0] != 8'hFF)
      |=> (low_q[0] == $past(low_q[0]) + 8'h01))
      else $error("timer missed a machine cycle");

   a_irq_level: assert property (
      (stat_q[0] && ien_q[0] && !wr_i) |=> irq_o)
      else $error("enabled status gave no interrupt");

endmodule : timer_pair

/* File: timer_pair_defs.svh */
// Purpose: Offsets, field positions, reset values and widths of the timer pair
// Assumes: Byte-wide register port, one register per address
// Notes:   Included by the timer pair and its count source
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define OFS_MODE       4'h0     // Shared mode register
`define OFS_CTRL       4'h1     // Run bits and overflow flags
`define OFS_LOW0       4'h2     // Unit 0 low count byte
`define OFS_LOW1       4'h3     // Unit 1 low count byte
`define OFS_HIGH0      4'h4     // Unit 0 high count byte
`define OFS_HIGH1      4'h5     // Unit 1 high count byte
`define OFS_IRQ_STAT   4'h6     // Sticky event status, read only
`define OFS_IRQ_CLR    4'h7     // Write one to clear status, write only
`define OFS_IRQ_EN     4'h8     // Interrupt enable

// ********************************************************************
// Field positions
// ********************************************************************
`define UNIT_STRIDE    4        // Mode register bits per unit
`define GATE_BIT       3        // Pin-qualify bit within a unit nibble
`define SEL_BIT        2        // Counter select bit within a unit nibble
`define MODE_LSB       0        // Mode field low bit within a unit nibble
`define OVF1_BIT       7        // Unit 1 overflow flag in control reg
`define RUN1_BIT       6        // Unit 1 run bit in control reg
`define OVF0_BIT       5        // Unit 0 overflow flag in control reg
`define RUN0_BIT       4        // Unit 0 run bit in control reg

// ********************************************************************
// Reset values and widths
// ********************************************************************
`define MODE_RST       8'h00
`define CTRL_RST       8'h00
`define COUNT_RST      8'h00
`define ADDR_W         4
`define DATA_W         8

`endif

/* File: timer_pair_pkg.sv */
// Purpose: Types shared by the timer pair
// Assumes: Nothing beyond the defs header
// Notes:   Enum order gives the binary mode encoding
package timer_pair_pkg;

   // ********************************************************************
   // Operating modes, 00 to 11 in declaration order
   // ********************************************************************
   typedef enum logic [1:0] {
      MODE_PRESCALE13,   // 13-bit count
      MODE_COUNT16,      // 16-bit count
      MODE_RELOAD8,      // 8-bit auto-reload
      MODE_SPLIT         // Split or hold
   } mode_t;

endpackage : timer_pair_pkg

/* File: count_source.sv */
// Purpose: Count enable for one unit: run, pin qualify and input select
// Assumes: Pins synchronous to clock_i
// Notes:   Counter input counts on a falling transition
`timescale 1ns/1ps
`include "timer_pair_defs.svh"

module count_source (
   input  wire logic clock_i,        // Machine-cycle clock
   input  wire logic rst_n_i,        // Synchronised reset
   input  wire logic run_i,          // Run bit
   input  wire logic gate_en_i,      // Pin-qualify bit
   input  wire logic gate_pin_i,     // External interrupt pin level
   input  wire logic counter_sel_i,  // 1 counts the pin, 0 machine cycles
   input  wire logic count_pin_i,    // External count input
   output logic      tick_o          // Count one this cycle
);

   logic pin_prev_q;                 // Count pin one cycle ago

   // ********************************************************************
   // Edge memory
   // ********************************************************************
   // Reset to the idle low level, so no false fall follows reset
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= count_pin_i;
      end
   end

   // Run and pin qualify gate the count; select picks its source
   always_comb begin
      tick_o = run_i && (!gate_en_i || gate_pin_i) &&
               (counter_sel_i ? (pin_prev_q && !count_pin_i) : 1'b1);
   end

endmodule : count_source

/* File: pin_source.sv */
// Purpose: Far-side pins of the timer pair: gate levels and count pulses
// Assumes: Pins change just after a rising edge, by non-blocking assignment
// Notes:   Count pins idle low; only the falling half of a pulse counts
`timescale 1ns/1ps

module pin_source (
   input  wire logic clock_i,  // Machine clock
   output logic      gate0_o,  // Unit 0 gate pin
   output logic      gate1_o,  // Unit 1 gate pin
   output logic      cnt0_o,   // Unit 0 count pin
   output logic      cnt1_o    // Unit 1 count pin
);
   // ********************************************************************
   // Pin levels at time zero
   // ********************************************************************
   initial begin
      gate0_o = 1'b0;
      gate1_o = 1'b0;
      cnt0_o  = 1'b0;
      cnt1_o  = 1'b0;
   end

   // Gate levels, held until changed
   task automatic set_gates(input logic g0, input logic g1);
      @(posedge clock_i);
      gate0_o <= g0;
      gate1_o <= g1;
   endtask : set_gates

   // Whole pulses on both count pins, two cycles high then two low
   task automatic pulse_pins(input int n);
      repeat (n) begin
         @(posedge clock_i);
         cnt0_o <= 1'b1;
         cnt1_o <= 1'b1;
         repeat (2) @(posedge clock_i);
         cnt0_o <= 1'b0;
         cnt1_o <= 1'b0;
         @(posedge clock_i);
      end
   endtask : pulse_pins
endmodule : pin_source

/* File: testbench.sv */
// Purpose: Self-checking bench for the timer pair
// Assumes: Register port answers one cycle after the read strobe
// Notes:   A run window of n idle cycles gives n plus two count ticks
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
`define CHECK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("Error t=%0t got %0h exp %0h", $time, a, e); end end

module testbench
   import timer_pair_pkg::*;
;
   logic       clock;     // Machine clock
   logic       rstn;      // Reset, active low
   logic [3:0] addr;      // Register address
   logic [7:0] wdata;     // Write data
   logic       wr;        // Write strobe
   logic       rd;        // Read strobe
   logic [7:0] rdata;     // Read data
   logic       irq;       // Interrupt level
   logic [1:0] ovf;       // Overflow flags
   logic       baud;      // Baud pulse
   logic       g0, g1, c0, c1;  // Far-side pins
   logic [7:0] d;         // Last read value
   int         n_errors;  // Mismatches
   int         n_checks;  // Comparisons
   int         n_baud;    // Baud pulses seen

   timer_pair u_dut (.clock_i(clock), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .unit0_irq_pin_i(g0), .unit1_irq_pin_i(g1),
      .count0_pin_i(c0), .count1_pin_i(c1), .rdata_o(rdata), .irq_o(irq),
      .overflow_flag_o(ovf), .baud_tick_o(baud));
   pin_source u_pins (.clock_i(clock), .gate0_o(g0), .gate1_o(g1), .cnt0_o(c0), .cnt1_o(c1));

   // ********************************************************************
   // Clock, baud pulse count and bus tasks
   // ********************************************************************
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) if (baud === 1'b1) n_baud++;

   // One-cycle write strobe
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      wr <= 1'b1; addr <= a; wdata <= v;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock);
      rd <= 1'b1; addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   // Run bits on for n idle cycles, then all off
   task automatic run(input logic [7:0] c, input int n);
      wr_reg(`OFS_CTRL, c);
      repeat (n) @(posedge clock);
      wr_reg(`OFS_CTRL, 8'h00);
   endtask : run

   // Stop, clear events, load mode and counts
   task automatic setup(input logic [7:0] m, l0, h0, l1, h1);
      wr_reg(`OFS_CTRL, 8'h00);
      wr_reg(`OFS_IRQ_CLR, 8'h03);
      wr_reg(`OFS_MODE, m);
      wr_reg(`OFS_LOW0, l0);
      wr_reg(`OFS_HIGH0, h0);
      wr_reg(`OFS_LOW1, l1);
      wr_reg(`OFS_HIGH1, h1);
   endtask : setup

   // ********************************************************************
   // Scenarios
   // ********************************************************************
   task automatic t_reset();
      rd_reg(`OFS_MODE);  `CHECK(d, `MODE_RST)
      rd_reg(`OFS_CTRL);  `CHECK(d, `CTRL_RST)
      rd_reg(`OFS_LOW0);  `CHECK(d, `COUNT_RST)
      rd_reg(4'hF);       `CHECK(d, 8'h00)
      wr_reg(`OFS_IRQ_STAT, 8'hFF);
      rd_reg(`OFS_IRQ_STAT); `CHECK(d, 8'h00)
      $display("test reset done");
   endtask : t_reset

   // Mode 1 on both units, then the interrupt masked, enabled and cleared
   // Unit 0 wraps on the edge of the stop write: the flag set must win
   task automatic t_mode1_irq();
      setup(8'h11, 8'hFD, 8'hFF, 8'hFE, 8'h12);
      run(8'h50, 1);
      rd_reg(`OFS_LOW0);  `CHECK(d, 8'h00)
      rd_reg(`OFS_HIGH0); `CHECK(d, 8'h00)
      rd_reg(`OFS_LOW1);  `CHECK(d, 8'h01)
      rd_reg(`OFS_HIGH1); `CHECK(d, 8'h13)
      rd_reg(`OFS_CTRL);  `CHECK(d, 8'h20)
      rd_reg(`OFS_IRQ_STAT); `CHECK(d, 8'h01)
      `CHECK(ovf, 2'h1)
      `CHECK(irq, 1'b0)
      wr_reg(`OFS_IRQ_EN, 8'h01);
      repeat (2) @(posedge clock);
      #1 `CHECK(irq, 1'b1)
      wr_reg(`OFS_IRQ_CLR, 8'h01);
      repeat (2) @(posedge clock);
      #1 `CHECK(irq, 1'b0)
      wr_reg(`OFS_IRQ_EN, 8'h00);
      $display("test mode1 irq done");
   endtask : t_mode1_irq

   // Mode 0: 13-bit wrap keeps the top three low bits
   task automatic t_mode0();
      setup(8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00);
      run(8'h10, 0);
      rd_reg(`OFS_LOW0);  `CHECK(d, 8'hE1)
      rd_reg(`OFS_HIGH0); `CHECK(d, 8'h00)
      rd_reg(`OFS_IRQ_STAT); `CHECK(d, 8'h01)
      $display("test mode0 done");
   endtask : t_mode0

   // Mode 2 on both units: reload from the high byte, high byte kept
   task automatic t_mode2();
      int b;
      setup(8'h22, 8'hFF, 8'h10, 8'hFF, 8'hF0);
      b = n_baud;
      run(8'h50, 1);
      rd_reg(`OFS_LOW0);  `CHECK(d, 8'h12)
      rd_reg(`OFS_LOW1);  `CHECK(d, 8'hF2)
      rd_reg(`OFS_HIGH1); `CHECK(d, 8'hF0)
      rd_reg(`OFS_IRQ_STAT); `CHECK(d, 8'h03)
      `CHECK(n_baud - b, 1)
      $display("test mode2 done");
   endtask : t_mode2

   // Gate pins qualify each unit; a new run resumes the count
   task automatic t_gate();
      setup(8'h99, 8'h00, 8'h00, 8'h00, 8'h00);
      u_pins.set_gates(1'b0, 1'b1);
      run(8'h50, 3);
      rd_reg(`OFS_LOW0); `CHECK(d, 8'h00)
      rd_reg(`OFS_LOW1); `CHECK(d, 8'h05)
      u_pins.set_gates(1'b1, 1'b1);
      run(8'h50, 0);
      rd_reg(`OFS_LOW0); `CHECK(d, 8'h02)
      rd_reg(`OFS_LOW1); `CHECK(d, 8'h07)
      u_pins.set_gates(1'b0, 1'b0);
      $display("test gate done");
   endtask : t_gate

   // Counter select: only falling pin transitions count
   task automatic t_counter();
      setup(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
      wr_reg(`OFS_CTRL, 8'h50);
      u_pins.pulse_pins(4);
      repeat (3) @(posedge clock);
      wr_reg(`OFS_CTRL, 8'h00);
      rd_reg(`OFS_LOW0); `CHECK(d, 8'h04)
      rd_reg(`OFS_LOW1); `CHECK(d, 8'h04)
      $display("test counter done");
   endtask : t_counter

   // Split mode: high 0 uses unit 1 run and flag; unit 1 holds, then runs
   task automatic t_split();
      setup(8'h33, 8'h00, 8'hFE, 8'h00, 8'h00);
      run(8'h50, 1);
      rd_reg(`OFS_LOW0);  `CHECK(d, 8'h03)
      rd_reg(`OFS_HIGH0); `CHECK(d, 8'h01)
      rd_reg(`OFS_LOW1);  `CHECK(d, 8'h00)
      rd_reg(`OFS_IRQ_STAT); `CHECK(d, 8'h02)
      wr_reg(`OFS_MODE, 8'h03);
      run(8'h40, 0);
      rd_reg(`OFS_LOW1);  `CHECK(d, 8'h02)
      $display("test split done");
   endtask : t_split

   // ********************************************************************
   // Verdict, watchdog and main sequence
   // ********************************************************************
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   // Tests need well under a thousand cycles
   initial begin
      #500000;
      n_errors++;
      complete_run();
   end

   initial begin
      n_errors = 0; n_checks = 0; n_baud = 0;
      rstn = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset();
      t_mode1_irq();
      t_mode0();
      t_mode2();
      t_gate();
      t_counter();
      t_split();
      complete_run();
   end
endmodule : testbench
